// ===== strap_pkg.sv
// Operation
// RL1: memory strap lines 7..0 land one-to-one in the low memory module register.
// RL2: memory strap lines 15..8 land one-to-one in the high memory module register.
// RL3: software alone reads module type and speed and programs memory control.
// RL4: clock register takes strap lines 20..16 in bits 4..0, line 23 in bit 5.
// RL5: only bit 4 of the clock register accepts software writes.
// RL6: clock register bit 4 picks the dot clock source.
// RL7: clock register bit 3 picks the graphics clock source.
// RL8: clock register bit 2 low: host clock pin input; high: driven internally.
// RL9: clock register bit 1 low divides host clock by 3, high by 2.
// RL10: interface register takes strap lines 47..40 into bits 7..0.
// RL11: interface bit 5 places the second serial port, 1 internal.
// RL12: interface bit 4 low: first serial external plus six low colour outputs.
// RL13: test bus strap high overrides the first serial / colour selection.
// RL14: interface bit 3 places the parallel port, 1 internal.
// RL15: interface bit 2 places the keyboard and pointer controller, 1 internal.
// RL16: interface bit 1 chooses ISA at 0, local bus at 1.
// RL17: interface bit 0 chooses PCI at 0, PCMCIA at 1.
// RL18: socket register takes strap lines 53..48 into bits 5..0.
// RL19: socket bits 1..4 report 5 V, 3.3 V, lower and lowest supplies.
// RL20: socket bit 0 high drives panel colour bits 2..5 onto the spare pads.
// RL21: after reset each strap register holds the levels sampled on its lines.
// RL22: straps latch once after reset release and then stay fixed.
package strap_pkg;
   localparam int STRAP_LINES = 54;
   // register indices; the bus address is four times the index
   localparam logic [7:0] IDX_IFSEL = 8'h3C;
   localparam logic [7:0] IDX_SOCKET = 8'h3D;
   localparam logic [7:0] IDX_MEM_LOW = 8'h4A;
   localparam logic [7:0] IDX_MEM_HIGH = 8'h4B;
   localparam logic [7:0] IDX_CLOCK = 8'h4C;
   localparam logic [11:0] ADDR_IFSEL = {2'h0, IDX_IFSEL, 2'h0};
   localparam logic [11:0] ADDR_SOCKET = {2'h0, IDX_SOCKET, 2'h0};
   localparam logic [11:0] ADDR_MEM_LOW = {2'h0, IDX_MEM_LOW, 2'h0};
   localparam logic [11:0] ADDR_MEM_HIGH = {2'h0, IDX_MEM_HIGH, 2'h0};
   localparam logic [11:0] ADDR_CLOCK = {2'h0, IDX_CLOCK, 2'h0};
   // clock register fields
   localparam int CLK_TESTBUS = 0;
   localparam int CLK_PCI_DIV = 1;
   localparam int CLK_HOST = 2;
   localparam int CLK_GFX = 3;
   localparam int CLK_DOT = 4;
   localparam int CLK_LINE23 = 5;
   localparam logic [7:0] CLK_WRITE_MASK = 8'h10;
   // interface register fields
   localparam int IF_PCMCIA = 0;
   localparam int IF_LOCAL = 1;
   localparam int IF_KBD = 2;
   localparam int IF_PAR = 3;
   localparam int IF_SER1 = 4;
   localparam int IF_SER2 = 5;
   // socket register fields
   localparam int SOCK_PANEL = 0;
   localparam int SOCK_SUPPLY_LSB = 1;
   // last settle count before straps are frozen (synchroniser depth); the freeze follows one cycle later
   localparam logic [1:0] SETTLE_LAST = 2'h2;
   localparam logic [1:0] PCI_LAST_DIV3 = 2'h2;
   localparam logic [1:0] PCI_LAST_DIV2 = 2'h1;
   localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// ===== reset_strap_capture_registers.sv
// The APB register port was left to the implementer.
module reset_strap_capture_registers
   import strap_pkg::*;
(
   input wire logic core_clk, // 10 MHz core clock, also the host clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic [STRAP_LINES-1:0] strap_sample_lines, // board strap levels
   input wire logic [11:0] panel_colour_hi, // panel R,G,B bits 2..5 in pad order
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic straps_valid, // straps frozen
   output logic dot_clock_internal, // dot clock from internal source
   output logic graphics_clock_internal, // graphics clock from internal source
   output logic host_clock_oe_n, // host clock pin drive enable, low drives
   output logic pci_clk_tick, // one pulse per pci clock period
   output logic second_serial_internal, // second serial port internal
   output logic first_serial_internal, // first serial port internal
   output logic extra_low_colour_en, // six low colour outputs enabled
   output logic parallel_internal, // parallel port internal
   output logic keyboard_pointer_internal, // keyboard/pointer controller internal
   output logic local_bus_sel, // local bus instead of ISA
   output logic pcmcia_sel, // PCMCIA instead of PCI
   output logic [3:0] supply_avail, // lowest, lower, 3.3 V, 5 V present
   output logic [11:0] spare_pads_out, // panel colour on spare pads
   output logic spare_pads_oe_n // spare pad drive enable, low drives
);
   typedef struct packed {
      logic [STRAP_LINES-1:0] sync1;
      logic [STRAP_LINES-1:0] sync2;
      logic [1:0] settle;
      logic captured;
      logic [7:0] ifsel;
      logic [7:0] socket;
      logic [7:0] mem_low;
      logic [7:0] mem_high;
      logic [7:0] clock;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [1:0] pci_cnt;
      logic pci_tick;
      logic dot_int;
      logic gfx_int;
      logic host_oe_n;
      logic ser2_int;
      logic ser1_int;
      logic low_colour;
      logic par_int;
      logic kbd_int;
      logic local_sel;
      logic pcm_sel;
      logic [3:0] supply;
      logic [11:0] pads;
      logic pads_oe_n;
   } state_t;

   state_t s;
   state_t next_s;
   logic setup;
   logic write_done;

   assign setup = psel & ~penable;
   assign write_done = psel & penable & s.ready & pwrite;

   always_comb begin
      next_s = s;
      // first stage feeds only the second one
      next_s.sync1 = strap_sample_lines;
      next_s.sync2 = s.sync1;

      // wait for the synchroniser to fill, then freeze once until next reset
      if (!s.captured) begin
         if (s.settle == SETTLE_LAST) begin
            next_s.captured = 1'b1; // RL22
            next_s.mem_low = s.sync2[7:0]; // RL1 RL21
            next_s.mem_high = s.sync2[15:8]; // RL2 RL21
            next_s.clock = {2'h0, s.sync2[23], s.sync2[20:16]}; // RL4 RL21
            next_s.ifsel = s.sync2[47:40]; // RL10 RL21
            next_s.socket = {2'h0, s.sync2[53:48]}; // RL18 RL21
         end else begin
            next_s.settle = s.settle + 2'h1;
         end
      end

      // apb: one wait-free access cycle, data prepared in the setup cycle
      next_s.ready = 1'b0;
      next_s.err = 1'b0;
      if (setup) begin
         next_s.ready = 1'b1;
         next_s.rdata = 32'h0000_0000;
         if (paddr == ADDR_IFSEL) begin
            next_s.rdata[7:0] = s.ifsel;
         end else if (paddr == ADDR_SOCKET) begin
            next_s.rdata[7:0] = s.socket;
         end else if (paddr == ADDR_MEM_LOW) begin
            next_s.rdata[7:0] = s.mem_low;
         end else if (paddr == ADDR_MEM_HIGH) begin
            next_s.rdata[7:0] = s.mem_high;
         end else if (paddr == ADDR_CLOCK) begin
            next_s.rdata[7:0] = s.clock;
         end else begin
            next_s.err = 1'b1;
         end
      end
      // writes before the freeze would be lost to the capture, so they are ignored
      if (write_done && s.captured && paddr == ADDR_CLOCK) begin
         next_s.clock = (s.clock & ~CLK_WRITE_MASK) | (pwdata[7:0] & CLK_WRITE_MASK); // RL5
      end

      // pci clock: period of 3 or 2 host clocks
      next_s.pci_tick = 1'b0;
      if (s.pci_cnt >= (s.clock[CLK_PCI_DIV] ? PCI_LAST_DIV2 : PCI_LAST_DIV3)) begin // RL9
         next_s.pci_cnt = 2'h0;
         next_s.pci_tick = 1'b1;
      end else begin
         next_s.pci_cnt = s.pci_cnt + 2'h1;
      end

      // steering outputs follow the registers with no extra delay
      next_s.dot_int = next_s.clock[CLK_DOT]; // RL6
      next_s.gfx_int = next_s.clock[CLK_GFX]; // RL7
      next_s.host_oe_n = ~next_s.clock[CLK_HOST]; // RL8
      next_s.ser2_int = next_s.ifsel[IF_SER2]; // RL11
      // test bus strap blanks the first serial / colour choice entirely
      next_s.ser1_int = next_s.ifsel[IF_SER1] & ~next_s.clock[CLK_TESTBUS]; // RL12 RL13
      next_s.low_colour = next_s.captured & ~next_s.ifsel[IF_SER1]
         & ~next_s.clock[CLK_TESTBUS]; // RL12 RL13
      next_s.par_int = next_s.ifsel[IF_PAR]; // RL14
      next_s.kbd_int = next_s.ifsel[IF_KBD]; // RL15
      next_s.local_sel = next_s.ifsel[IF_LOCAL]; // RL16
      next_s.pcm_sel = next_s.ifsel[IF_PCMCIA]; // RL17
      next_s.supply = next_s.socket[SOCK_SUPPLY_LSB +: 4]; // RL19
      next_s.pads_oe_n = ~next_s.socket[SOCK_PANEL]; // RL20
      next_s.pads = next_s.socket[SOCK_PANEL] ? panel_colour_hi : 12'h000; // RL20
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign straps_valid = s.captured;
   assign dot_clock_internal = s.dot_int;
   assign graphics_clock_internal = s.gfx_int;
   assign host_clock_oe_n = s.host_oe_n;
   assign pci_clk_tick = s.pci_tick;
   assign second_serial_internal = s.ser2_int;
   assign first_serial_internal = s.ser1_int;
   assign extra_low_colour_en = s.low_colour;
   assign parallel_internal = s.par_int;
   assign keyboard_pointer_internal = s.kbd_int;
   assign local_bus_sel = s.local_sel;
   assign pcmcia_sel = s.pcm_sel;
   assign supply_avail = s.supply;
   assign spare_pads_out = s.pads;
   assign spare_pads_oe_n = s.pads_oe_n;

   // checks
   sequence clock_write_seq;
      write_done && s.captured && paddr == ADDR_CLOCK;
   endsequence

   sequence div3_seq;
      pci_clk_tick ##1 !pci_clk_tick ##1 !pci_clk_tick ##1 pci_clk_tick;
   endsequence

   a_mem_low_capture: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
      $rose(s.captured) |-> s.mem_low == $past(s.sync2[7:0]))
      else $error("low memory strap register not captured");

   a_mem_high_capture: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
      $rose(s.captured) |-> s.mem_high == $past(s.sync2[15:8]))
      else $error("high memory strap register not captured");

   a_clock_capture: assert property (@(posedge core_clk) disable iff (!nrst) // RL4
      $rose(s.captured) |-> s.clock == {2'h0, $past(s.sync2[23]), $past(s.sync2[20:16])})
      else $error("clock strap register not captured");

   a_clock_ro_bits: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
      clock_write_seq |=> (s.clock & ~CLK_WRITE_MASK) == $past(s.clock & ~CLK_WRITE_MASK)
      && s.clock[CLK_DOT] == $past(pwdata[CLK_DOT]))
      else $error("clock register write touched a fixed bit");

   a_dot_after_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
      clock_write_seq |=> dot_clock_internal == $past(pwdata[CLK_DOT]))
      else $error("dot clock select did not follow the write");

   a_host_pin_dir: assert property (@(posedge core_clk) disable iff (!nrst) // RL8
      $rose(s.captured) |-> host_clock_oe_n == !$past(s.sync2[18]))
      else $error("host clock pin direction wrong");

   a_pci_div_three: assert property (@(posedge core_clk) disable iff (!nrst) // RL9
      (pci_clk_tick && !s.clock[CLK_PCI_DIV] && $stable(s.clock[CLK_PCI_DIV])
      && s.captured) |-> div3_seq)
      else $error("pci clock not divided by three");

   a_pci_div_two: assert property (@(posedge core_clk) disable iff (!nrst) // RL9
      (pci_clk_tick && s.clock[CLK_PCI_DIV] && s.captured) |=> !pci_clk_tick ##1 pci_clk_tick)
      else $error("pci clock not divided by two");

   a_ifsel_capture: assert property (@(posedge core_clk) disable iff (!nrst) // RL10
      $rose(s.captured) |-> s.ifsel == $past(s.sync2[47:40]))
      else $error("interface strap register not captured");

   a_testbus_override: assert property (@(posedge core_clk) disable iff (!nrst) // RL13
      s.clock[CLK_TESTBUS] |-> !extra_low_colour_en && !first_serial_internal)
      else $error("test bus strap did not override serial selection");

   a_socket_capture: assert property (@(posedge core_clk) disable iff (!nrst) // RL18
      $rose(s.captured) |-> s.socket == {2'h0, $past(s.sync2[53:48])})
      else $error("socket strap register not captured");

   a_pads_follow: assert property (@(posedge core_clk) disable iff (!nrst) // RL20
      (s.captured && s.socket[SOCK_PANEL]) |=> spare_pads_out == $past(panel_colour_hi)
      && !spare_pads_oe_n)
      else $error("spare pads do not carry panel colour");

   a_straps_frozen: assert property (@(posedge core_clk) disable iff (!nrst) // RL22
      s.captured |=> $stable(s.ifsel) && $stable(s.socket) && $stable(s.mem_low)
      && $stable(s.mem_high) && s.captured)
      else $error("strap registers changed after capture");

   a_capture_time: assert property (@(posedge core_clk) disable iff (!nrst) // RL22
      $rose(s.settle == 2'h1) |-> ##1 !s.captured ##1 s.captured)
      else $error("straps not frozen on time");
endmodule

// ===== strap_board.sv
module strap_board (
   input wire logic [53:0] setting, // levels chosen by the strap resistors
   output logic [53:0] strap_sample_lines // lines seen by the device
);
   timeunit 1ns;
   timeprecision 1ns;
   // resistors hold their level at all times, so no line ever floats
   assign strap_sample_lines = setting;
endmodule

// ===== tb_top.sv
module tb_top
   import strap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [53:0] setting = '0;
   logic [53:0] strap_sample_lines;
   logic [11:0] panel_colour_hi = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, straps_valid, dot_clock_internal, graphics_clock_internal;
   logic host_clock_oe_n, pci_clk_tick, second_serial_internal, first_serial_internal;
   logic extra_low_colour_en, parallel_internal, keyboard_pointer_internal;
   logic local_bus_sel, pcmcia_sel, spare_pads_oe_n;
   logic [3:0] supply_avail;
   logic [11:0] spare_pads_out;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int comparisons = 0;

   always #50 core_clk = ~core_clk;

   strap_board i_board (.setting, .strap_sample_lines);

   reset_strap_capture_registers i_dut (.core_clk, .nrst, .strap_sample_lines,
      .panel_colour_hi, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .straps_valid, .dot_clock_internal, .graphics_clock_internal,
      .host_clock_oe_n, .pci_clk_tick, .second_serial_internal, .first_serial_internal,
      .extra_low_colour_en, .parallel_internal, .keyboard_pointer_internal,
      .local_bus_sel, .pcmcia_sel, .supply_avail, .spare_pads_out, .spare_pads_oe_n);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // the request is held until pready is seen high at a falling edge, then dropped at the next rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // look mid-cycle: pready stands for one cycle and is sampled at the next rising edge
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20) mismatches++;
      rd = prdata;
      err = pslverr;
      @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
         input logic e);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
      chk("pslverr", e, err);
   endtask

   task automatic phase(input logic [53:0] s, input logic [11:0] pc);
      logic [7:0] ck;
      int g;
      ck = {2'h0, s[23], s[20:16]};
      setting <= s;
      panel_colour_hi <= pc;
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      g = 0;
      while (straps_valid !== 1'b1 && g < 20) begin
         @(posedge core_clk);
         g++;
      end
      // later changes on the board must not reach the registers
      setting <= ~s;
      rdchk("mem_low", ADDR_MEM_LOW, {24'h0, s[7:0]}, 1'b0);
      rdchk("mem_high", ADDR_MEM_HIGH, {24'h0, s[15:8]}, 1'b0);
      rdchk("clock", ADDR_CLOCK, {24'h0, ck}, 1'b0);
      rdchk("ifsel", ADDR_IFSEL, {24'h0, s[47:40]}, 1'b0);
      rdchk("socket", ADDR_SOCKET, {26'h0, s[53:48]}, 1'b0);
      #1;
      chk("dot", ck[4], dot_clock_internal);
      chk("gfx", ck[3], graphics_clock_internal);
      chk("host_oe_n", !ck[2], host_clock_oe_n);
      chk("ser2", s[45], second_serial_internal);
      chk("ser1", s[44] && !s[16], first_serial_internal);
      chk("extra", !s[44] && !s[16], extra_low_colour_en);
      chk("par", s[43], parallel_internal);
      chk("kbd", s[42], keyboard_pointer_internal);
      chk("local", s[41], local_bus_sel);
      chk("pcmcia", s[40], pcmcia_sel);
      chk("supply", s[52:49], supply_avail);
      chk("pads_oe_n", !s[48], spare_pads_oe_n);
      chk("pads", s[48] ? pc : 12'h000, spare_pads_out);
      g = 0;
      while (pci_clk_tick !== 1'b1 && g < 10) begin
         @(posedge core_clk);
         #1;
         g++;
      end
      g = 0;
      do begin
         @(posedge core_clk);
         #1;
         g++;
      end while (pci_clk_tick !== 1'b1 && g < 10);
      chk("pci_gap", s[17] ? 2 : 3, g);
      $display("strap phase done");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      phase({6'h2B, 8'hAD, 16'h0000, 8'h9C, 8'h5A, 8'hC3}, 12'hA5C);
      apb(1'b1, ADDR_CLOCK, 32'h0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("dot_clr", 1'b0, dot_clock_internal);
      rdchk("clock_clr", ADDR_CLOCK, 32'h2C, 1'b0);
      apb(1'b1, ADDR_CLOCK, 32'hFF);
      repeat (2) @(posedge core_clk);
      #1;
      chk("dot_set", 1'b1, dot_clock_internal);
      rdchk("clock_set", ADDR_CLOCK, 32'h3C, 1'b0);
      apb(1'b1, ADDR_IFSEL, 32'hFF);
      rdchk("ifsel_ro", ADDR_IFSEL, 32'hAD, 1'b0);
      rdchk("unmapped", 12'h0F8, 32'h0, 1'b1);
      $display("write phase done");
      phase({6'h14, 8'h52, 16'hFFFF, 8'h63, 8'hA5, 8'h3C}, 12'h3B1);
      print_verdict();
   end

   // the whole sequence needs under a hundred cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      mismatches++;
      print_verdict();
   end
endmodule
